// ### rtl/cix_pkg.sv
package cix_pkg;
   // ************************************************************
   // register map (APB byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSTR = 8'h04;
   localparam logic [7:0] OFS_WORK = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_FILE_ADDR = 8'h10;
   localparam logic [7:0] OFS_FILE_DATA = 8'h14;
   localparam logic [7:0] OFS_PC = 8'h18;
   localparam logic [7:0] OFS_STACK_TOP = 8'h1c;
   localparam logic [7:0] OFS_TABLE_PAGE = 8'h20;
   localparam logic [7:0] OFS_ROM_ADDR = 8'h24;
   localparam logic [7:0] OFS_ROM_DATA = 8'h28;
   localparam logic [7:0] OFS_CORE = 8'h2c;

   // ************************************************************
   // field layout
   // ************************************************************
   localparam int STAT_C = 0;
   localparam int STAT_DC = 1;
   localparam int STAT_Z = 2;
   localparam int STAT_PD = 3;
   localparam int STAT_TO = 4;
   localparam int CORE_BUSY = 0;
   localparam int CORE_SLEEP = 1;
   localparam int CORE_SKIP = 2;
   localparam int CORE_WDT_CLR = 3;
   localparam int CTRL_WAKE = 1;
   localparam int DEST_BIT = 8;
   localparam logic [7:0] FILE_ADDR_MAX = 8'hbf;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [4:0] STATUS_RST = 5'h18;
   localparam logic [10:0] PC_RST = 11'h000;

   // ************************************************************
   // opcodes (instruction bits 15:9)
   // ************************************************************
   typedef enum logic [6:0] {
      OP_NOP = 7'h00,
      OP_RET_LIT = 7'h01,
      OP_RETURN = 7'h02,
      OP_ROT_L = 7'h03,
      OP_SHL_0 = 7'h04,
      OP_SHL_1 = 7'h05,
      OP_ROT_LC = 7'h06,
      OP_ROT_R = 7'h07,
      OP_SHR_0 = 7'h08,
      OP_SHR_1 = 7'h09,
      OP_ROT_RC = 7'h0a,
      OP_SLEEP = 7'h0b,
      OP_SUB_B = 7'h0c,
      OP_SUB_F = 7'h0d,
      OP_SUB_L = 7'h0e,
      OP_NIB_X = 7'h0f,
      OP_ROM_LO = 7'h10,
      OP_ROM_HI = 7'h11,
      OP_SK_EQ = 7'h12,
      OP_SK_NE = 7'h13,
      OP_SK_WZ = 7'h14,
      OP_SK_FZ = 7'h15,
      OP_SK_FNZ = 7'h16,
      OP_XOR_F = 7'h17,
      OP_XOR_L = 7'h18
   } cix_op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_SECOND = 4'b0100,
      ST_SLEEP = 4'b1000
   } cix_state_t;

   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic dc;
   } cix_alu_t;
endpackage

// ### rtl/cix_exec.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module cix_exec #(
   parameter int ROM_DEPTH = 2048,
   parameter int FILE_DEPTH = 192
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // core side
   output logic sleep_out,
   output logic wdt_clear_out
);
   // lookup index is a plain bit slice, so the depth must be a power of two
   if (ROM_DEPTH < 2 || ROM_DEPTH > 2048 || (ROM_DEPTH & (ROM_DEPTH - 1)) != 0
       || FILE_DEPTH != 192) begin
      $error("cix_exec: unsupported memory sizes");
   end

   // ************************************************************
   // state
   // ************************************************************
   logic [15:0] rom_mem [ROM_DEPTH];
   logic [7:0] file_mem [FILE_DEPTH];
   logic [15:0] instr_reg;
   logic [7:0] work_reg;
   logic [4:0] status_reg;
   logic [10:0] pc_reg;
   logic [10:0] stack_top_reg;
   logic [2:0] table_page_reg;
   logic [10:0] rom_addr_reg;
   logic [7:0] file_addr_reg;
   logic skip_reg;
   logic wdt_clear_reg;
   cix_pkg::cix_state_t state_reg;

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ************************************************************
   // decode and operands
   // ************************************************************
   logic [6:0] opc;
   logic [7:0] lit;
   logic dest;
   logic [7:0] fval;
   logic [7:0] faddr;
   logic faddr_ok;
   logic [10:0] tbl_addr;
   logic [15:0] tbl_word;
   assign opc = instr_reg[15:9];
   assign lit = instr_reg[7:0];
   assign dest = instr_reg[cix_pkg::DEST_BIT];
   assign faddr = instr_reg[7:0];
   assign faddr_ok = faddr <= cix_pkg::FILE_ADDR_MAX;
   assign fval = faddr_ok ? file_mem[faddr] : 8'h00;
   assign tbl_addr = {table_page_reg, fval};
   assign tbl_word = rom_mem[tbl_addr[$clog2(ROM_DEPTH)-1:0]];

   wire apb_wr = psel_in && penable_in && pwrite_in;
   wire start = apb_wr && is_addr(paddr_in, cix_pkg::OFS_CTRL) && pwdata_in[0]
      && state_reg == cix_pkg::ST_IDLE;
   wire wake = apb_wr && is_addr(paddr_in, cix_pkg::OFS_CTRL)
      && pwdata_in[cix_pkg::CTRL_WAKE];

   // ************************************************************
   // alu
   // ************************************************************
   function automatic cix_pkg::cix_alu_t add3(input logic [7:0] a, input logic [7:0] b,
                                              input logic ci);
      cix_pkg::cix_alu_t r;
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      r.res = s[7:0];
      r.c = s[8];
      r.dc = h[4];
      return r;
   endfunction

   cix_pkg::cix_alu_t alu;
   logic wr_dest;
   logic set_cdc;
   logic set_z;
   logic set_c_only;
   logic take_skip;
   always_comb begin
      alu = '{res: fval, c: status_reg[cix_pkg::STAT_C], dc: status_reg[cix_pkg::STAT_DC]};
      wr_dest = 1'b0;
      set_cdc = 1'b0;
      set_z = 1'b0;
      set_c_only = 1'b0;
      take_skip = 1'b0;
      case (opc)
         cix_pkg::OP_ROT_L: begin
            alu.res = {fval[6:0], fval[7]};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SHL_0: begin
            alu.res = {fval[6:0], 1'b0};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SHL_1: begin
            alu.res = {fval[6:0], 1'b1};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_ROT_LC: begin
            alu.res = {fval[6:0], status_reg[cix_pkg::STAT_C]};
            alu.c = fval[7];
            set_c_only = 1'b1;
            wr_dest = 1'b1;
         end
         cix_pkg::OP_ROT_R: begin
            alu.res = {fval[0], fval[7:1]};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SHR_0: begin
            alu.res = {1'b0, fval[7:1]};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SHR_1: begin
            alu.res = {1'b1, fval[7:1]};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_ROT_RC: begin
            alu.res = {status_reg[cix_pkg::STAT_C], fval[7:1]};
            alu.c = fval[0];
            set_c_only = 1'b1;
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SUB_B: begin
            alu = add3(fval, ~work_reg, status_reg[cix_pkg::STAT_C]);
            set_cdc = 1'b1;
            set_z = 1'b1;
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SUB_F: begin
            alu = add3(fval, ~work_reg, 1'b1);
            set_cdc = 1'b1;
            set_z = 1'b1;
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SUB_L: begin
            alu = add3(lit, ~work_reg, 1'b1);
            set_cdc = 1'b1;
            set_z = 1'b1;
         end
         cix_pkg::OP_NIB_X: begin
            alu.res = {fval[3:0], fval[7:4]};
            wr_dest = 1'b1;
         end
         cix_pkg::OP_SK_EQ: take_skip = work_reg == fval;
         cix_pkg::OP_SK_NE: take_skip = work_reg != fval;
         cix_pkg::OP_SK_WZ: take_skip = work_reg == 8'h00;
         cix_pkg::OP_SK_FZ: take_skip = fval == 8'h00;
         cix_pkg::OP_SK_FNZ: take_skip = fval != 8'h00;
         cix_pkg::OP_XOR_F: begin
            alu.res = work_reg ^ fval;
            set_z = 1'b1;
            wr_dest = 1'b1;
         end
         cix_pkg::OP_XOR_L: begin
            alu.res = work_reg ^ lit;
            set_z = 1'b1;
         end
         default: alu.res = fval;
      endcase
   end

   wire to_file = wr_dest && dest;
   wire two_cycle = opc == cix_pkg::OP_RET_LIT || opc == cix_pkg::OP_RETURN
      || opc == cix_pkg::OP_ROM_LO || opc == cix_pkg::OP_ROM_HI || take_skip;

   // ************************************************************
   // sequencer
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= cix_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            cix_pkg::ST_IDLE: if (start) state_reg <= cix_pkg::ST_EXEC;
            cix_pkg::ST_EXEC: begin
               if (opc == cix_pkg::OP_SLEEP) begin
                  state_reg <= cix_pkg::ST_SLEEP;
               end else if (two_cycle) begin
                  state_reg <= cix_pkg::ST_SECOND;
               end else begin
                  state_reg <= cix_pkg::ST_IDLE;
               end
            end
            cix_pkg::ST_SECOND: state_reg <= cix_pkg::ST_IDLE;
            cix_pkg::ST_SLEEP: if (wake) state_reg <= cix_pkg::ST_IDLE;
            default: state_reg <= cix_pkg::ST_IDLE;
         endcase
      end
   end

   wire exec = state_reg == cix_pkg::ST_EXEC;

   // ************************************************************
   // work register, flags, pc
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         work_reg <= cix_pkg::WORK_RST;
      end else if (exec) begin
         case (opc)
            cix_pkg::OP_RET_LIT, cix_pkg::OP_SUB_L, cix_pkg::OP_XOR_L:
               work_reg <= opc == cix_pkg::OP_RET_LIT ? lit : alu.res;
            cix_pkg::OP_ROM_LO: work_reg <= tbl_word[7:0];
            cix_pkg::OP_ROM_HI: work_reg <= tbl_word[15:8];
            default: if (wr_dest && !dest) work_reg <= alu.res;
         endcase
      end else if (apb_wr && is_addr(paddr_in, cix_pkg::OFS_WORK)) begin
         work_reg <= pwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         status_reg <= cix_pkg::STATUS_RST;
      end else if (exec) begin
         if (set_cdc || set_c_only) status_reg[cix_pkg::STAT_C] <= alu.c;
         if (set_cdc) status_reg[cix_pkg::STAT_DC] <= alu.dc;
         if (set_z) status_reg[cix_pkg::STAT_Z] <= alu.res == 8'h00;
         if (opc == cix_pkg::OP_SLEEP) begin
            status_reg[cix_pkg::STAT_TO] <= 1'b1;
            status_reg[cix_pkg::STAT_PD] <= 1'b0;
         end
      end else if (apb_wr && is_addr(paddr_in, cix_pkg::OFS_STATUS)) begin
         status_reg <= pwdata_in[4:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pc_reg <= cix_pkg::PC_RST;
      end else if (exec) begin
         if (opc == cix_pkg::OP_RET_LIT || opc == cix_pkg::OP_RETURN) begin
            pc_reg <= stack_top_reg;
         end else begin
            pc_reg <= pc_reg + (take_skip ? 11'd2 : 11'd1);
         end
      end else if (apb_wr && is_addr(paddr_in, cix_pkg::OFS_PC)) begin
         pc_reg <= pwdata_in[10:0];
      end
   end

   // skip flag shows the discarded slot executing as a nop
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         skip_reg <= 1'b0;
      end else if (exec) begin
         skip_reg <= take_skip;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wdt_clear_reg <= 1'b0;
      end else begin
         wdt_clear_reg <= exec && opc == cix_pkg::OP_SLEEP;
      end
   end

   // ************************************************************
   // memories and software-held registers
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (exec && to_file && faddr_ok) begin
         file_mem[faddr] <= alu.res;
      end else if (apb_wr && is_addr(paddr_in, cix_pkg::OFS_FILE_DATA)
                   && file_addr_reg <= cix_pkg::FILE_ADDR_MAX) begin
         file_mem[file_addr_reg] <= pwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (apb_wr && is_addr(paddr_in, cix_pkg::OFS_ROM_DATA)) begin
         rom_mem[rom_addr_reg[$clog2(ROM_DEPTH)-1:0]] <= pwdata_in[15:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         instr_reg <= 16'h0000;
         stack_top_reg <= 11'h000;
         table_page_reg <= 3'h0;
         rom_addr_reg <= 11'h000;
         file_addr_reg <= 8'h00;
      end else if (apb_wr && state_reg == cix_pkg::ST_IDLE) begin
         if (is_addr(paddr_in, cix_pkg::OFS_INSTR)) instr_reg <= pwdata_in[15:0];
         if (is_addr(paddr_in, cix_pkg::OFS_STACK_TOP)) stack_top_reg <= pwdata_in[10:0];
         if (is_addr(paddr_in, cix_pkg::OFS_TABLE_PAGE)) table_page_reg <= pwdata_in[2:0];
         if (is_addr(paddr_in, cix_pkg::OFS_ROM_ADDR)) rom_addr_reg <= pwdata_in[10:0];
         if (is_addr(paddr_in, cix_pkg::OFS_FILE_ADDR)) file_addr_reg <= pwdata_in[7:0];
      end
   end

   // ************************************************************
   // apb read side
   // ************************************************************
   logic [31:0] rdata;
   logic known;
   always_comb begin
      rdata = 32'h0000_0000;
      known = 1'b1;
      case (paddr_in)
         cix_pkg::OFS_CTRL: rdata = 32'h0000_0000;
         cix_pkg::OFS_INSTR: rdata = {16'h0000, instr_reg};
         cix_pkg::OFS_WORK: rdata = {24'h000000, work_reg};
         cix_pkg::OFS_STATUS: rdata = {27'h0, status_reg};
         cix_pkg::OFS_FILE_ADDR: rdata = {24'h000000, file_addr_reg};
         cix_pkg::OFS_FILE_DATA:
            rdata = file_addr_reg <= cix_pkg::FILE_ADDR_MAX
               ? {24'h000000, file_mem[file_addr_reg]} : 32'h0000_0000;
         cix_pkg::OFS_PC: rdata = {21'h0, pc_reg};
         cix_pkg::OFS_STACK_TOP: rdata = {21'h0, stack_top_reg};
         cix_pkg::OFS_TABLE_PAGE: rdata = {29'h0, table_page_reg};
         cix_pkg::OFS_ROM_ADDR: rdata = {21'h0, rom_addr_reg};
         cix_pkg::OFS_ROM_DATA: rdata = {16'h0000, rom_mem[rom_addr_reg[$clog2(ROM_DEPTH)-1:0]]};
         cix_pkg::OFS_CORE: rdata = {28'h0, wdt_clear_reg, skip_reg,
                                     state_reg == cix_pkg::ST_SLEEP,
                                     state_reg != cix_pkg::ST_IDLE};
         default: known = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (psel_in && !penable_in && !pwrite_in) begin
         prdata_out <= rdata;
      end
   end

   // zero-wait slave; unmapped addresses answer with an error
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !known;
   assign sleep_out = state_reg == cix_pkg::ST_SLEEP;
   assign wdt_clear_out = wdt_clear_reg;
endmodule

// ### verif/cix_exec_monitor.sv
`timescale 1ns/1ps
module cix_exec_monitor (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // core
   input wire logic sleep_out,
   input wire logic wdt_clear_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   logic acc;
   logic wake;
   logic mapped;
   assign acc = psel_in && penable_in;
   assign wake = acc && pwrite_in && paddr_in == cix_pkg::OFS_CTRL
      && pwdata_in[cix_pkg::CTRL_WAKE];
   // only aligned words are judged; sub-word decode is left open
   assign mapped = paddr_in <= cix_pkg::OFS_CORE;

   a_wdt_single_pulse:
   assert property (wdt_clear_out |=> !wdt_clear_out)
      else $error("watchdog clear wider than one cycle");
   a_sleep_with_clear:
   assert property ($rose(sleep_out) |-> ##[0:1] wdt_clear_out)
      else $error("sleep entered without watchdog clear");
   a_sleep_holds_on:
   assert property (sleep_out && !wake |=> sleep_out)
      else $error("sleep left without wake write");
   a_wake_leaves_sleep:
   assert property (sleep_out && wake |-> ##[1:2] !sleep_out)
      else $error("wake write did not end sleep");
   a_ready_zero_wait:
   assert property (acc |-> pready_out)
      else $error("access phase without ready");
   a_err_on_unmapped:
   assert property (acc && paddr_in[1:0] == 2'b00 |-> pslverr_out == !mapped)
      else $error("slave error does not match decode");
   a_err_only_access:
   assert property (!acc |-> !pslverr_out)
      else $error("slave error outside access phase");
   a_rdata_held:
   assert property (!(psel_in && !penable_in && !pwrite_in) |=> $stable(prdata_out))
      else $error("read data moved outside read setup");

   cover property ($rose(sleep_out));
   cover property (acc && pslverr_out);
   cover property (wake && sleep_out);
endmodule

bind cix_exec cix_exec_monitor cix_exec_monitor_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .sleep_out(sleep_out), .wdt_clear_out(wdt_clear_out));

// ### verif/cix_exec_tb.sv
`timescale 1ns/1ps
module cix_exec_tb;
   // ****
   // stimulus and state
   // ****
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, sleep_out, wdt_clear_out;
   logic [31:0] rd;
   logic err;
   logic seen_clr = 1'b0;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int polls = 0;
   cix_pkg::cix_op_t sh_op[7] = '{cix_pkg::OP_ROT_L, cix_pkg::OP_ROT_R, cix_pkg::OP_SHL_0,
      cix_pkg::OP_SHL_1, cix_pkg::OP_SHR_0, cix_pkg::OP_SHR_1, cix_pkg::OP_NIB_X};
   logic [7:0] sh_src[7] = '{8'h96, 8'h69, 8'h96, 8'h69, 8'h69, 8'h96, 8'h96};
   logic [7:0] sh_exp[7] = '{8'h2d, 8'hb4, 8'h2c, 8'hd3, 8'h34, 8'hcb, 8'h69};
   cix_pkg::cix_op_t sk_op[5] = '{cix_pkg::OP_SK_EQ, cix_pkg::OP_SK_NE, cix_pkg::OP_SK_WZ,
      cix_pkg::OP_SK_FZ, cix_pkg::OP_SK_FNZ};
   // bit j: skip taken for sk_op[j], with work 0 and file 0 or 1
   logic [4:0] sk_tk[2] = '{5'b01101, 5'b10110};

   always #2 clk_in = ~clk_in;

   cix_exec cix_exec_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .sleep_out(sleep_out), .wdt_clear_out(wdt_clear_out));

   always @(posedge clk_in) begin
      if (wdt_clear_out === 1'b1) seen_clr <= 1'b1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         $display("MISMATCH t=%0t timeout cycles=%h limit=%h", $time, cycles, 20000);
         complete_run();
      end
   end

   // ****
   // helpers
   // ****
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic setf(input logic [7:0] v);
      wr(cix_pkg::OFS_FILE_ADDR, 32'h20);
      wr(cix_pkg::OFS_FILE_DATA, {24'h0, v});
   endtask

   // poll busy rather than assume a count: two-cycle ops differ
   task automatic run(input cix_pkg::cix_op_t op, input logic d, input logic [7:0] k);
      wr(cix_pkg::OFS_INSTR, {16'h0, op, d, k});
      wr(cix_pkg::OFS_CTRL, 32'h1);
      polls = 0;
      do begin
         apb(1'b0, cix_pkg::OFS_CORE, 32'h0);
         polls++;
      end while (rd[0] !== 1'b0 && polls < 20);
      chk({31'h0, rd[0]}, 32'h0);
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_shift;
      for (int i = 0; i < 7; i++) begin
         wr(cix_pkg::OFS_STATUS, 32'h1f);
         setf(sh_src[i]);
         run(sh_op[i], 1'b0, 8'h20);
         rchk(cix_pkg::OFS_WORK, {24'h0, sh_exp[i]});
         rchk(cix_pkg::OFS_STATUS, 32'h1f);
      end
      setf(8'h96);
      run(cix_pkg::OP_ROT_L, 1'b1, 8'h20);
      rchk(cix_pkg::OFS_FILE_DATA, 32'h2d);
      rchk(cix_pkg::OFS_WORK, 32'h69);
      run(cix_pkg::OP_SHL_1, 1'b0, 8'hc0);
      rchk(cix_pkg::OFS_WORK, 32'h01);
   endtask

   task automatic t_carry;
      wr(cix_pkg::OFS_STATUS, 32'h1f);
      setf(8'h16);
      run(cix_pkg::OP_ROT_LC, 1'b0, 8'h20);
      rchk(cix_pkg::OFS_WORK, 32'h2d);
      rchk(cix_pkg::OFS_STATUS, 32'h1e);
      wr(cix_pkg::OFS_STATUS, 32'h19);
      setf(8'h02);
      run(cix_pkg::OP_ROT_RC, 1'b0, 8'h20);
      rchk(cix_pkg::OFS_WORK, 32'h81);
      rchk(cix_pkg::OFS_STATUS, 32'h18);
   endtask

   task automatic t_sub;
      wr(cix_pkg::OFS_WORK, 32'h01);
      setf(8'h10);
      wr(cix_pkg::OFS_STATUS, 32'h18);
      run(cix_pkg::OP_SUB_F, 1'b1, 8'h20);
      rchk(cix_pkg::OFS_FILE_DATA, 32'h0f);
      rchk(cix_pkg::OFS_WORK, 32'h01);
      rchk(cix_pkg::OFS_STATUS, 32'h19);
      wr(cix_pkg::OFS_WORK, 32'h05);
      run(cix_pkg::OP_SUB_L, 1'b0, 8'h05);
      rchk(cix_pkg::OFS_WORK, 32'h00);
      rchk(cix_pkg::OFS_STATUS, 32'h1f);
      wr(cix_pkg::OFS_WORK, 32'h00);
      setf(8'h00);
      wr(cix_pkg::OFS_STATUS, 32'h18);
      run(cix_pkg::OP_SUB_B, 1'b0, 8'h20);
      rchk(cix_pkg::OFS_WORK, 32'hff);
      rchk(cix_pkg::OFS_STATUS, 32'h18);
   endtask

   task automatic t_xor;
      wr(cix_pkg::OFS_WORK, 32'h5a);
      setf(8'h5a);
      wr(cix_pkg::OFS_STATUS, 32'h18);
      run(cix_pkg::OP_XOR_F, 1'b0, 8'h20);
      rchk(cix_pkg::OFS_WORK, 32'h00);
      rchk(cix_pkg::OFS_STATUS, 32'h1c);
      run(cix_pkg::OP_XOR_L, 1'b0, 8'hf0);
      chk(32'(polls), 32'h1);
      rchk(cix_pkg::OFS_WORK, 32'hf0);
      rchk(cix_pkg::OFS_STATUS, 32'h18);
   endtask

   task automatic t_skip;
      wr(cix_pkg::OFS_WORK, 32'h00);
      for (int k = 0; k < 2; k++) begin
         setf(8'(k));
         for (int j = 0; j < 5; j++) begin
            wr(cix_pkg::OFS_PC, 32'h10);
            run(sk_op[j], 1'b0, 8'h20);
            chk({31'h0, rd[2]}, {31'h0, sk_tk[k][j]});
            chk(32'(polls), 32'h1 + {31'h0, sk_tk[k][j]});
            rchk(cix_pkg::OFS_PC, 32'h11 + {31'h0, sk_tk[k][j]});
         end
      end
   endtask

   task automatic t_ret_rom;
      wr(cix_pkg::OFS_STACK_TOP, 32'h123);
      wr(cix_pkg::OFS_STATUS, 32'h1f);
      run(cix_pkg::OP_RET_LIT, 1'b0, 8'ha5);
      chk(32'(polls), 32'h2);
      rchk(cix_pkg::OFS_WORK, 32'ha5);
      rchk(cix_pkg::OFS_PC, 32'h123);
      wr(cix_pkg::OFS_STACK_TOP, 32'h2b6);
      run(cix_pkg::OP_RETURN, 1'b0, 8'h00);
      chk(32'(polls), 32'h2);
      rchk(cix_pkg::OFS_PC, 32'h2b6);
      rchk(cix_pkg::OFS_STATUS, 32'h1f);
      wr(cix_pkg::OFS_TABLE_PAGE, 32'h5);
      wr(cix_pkg::OFS_ROM_ADDR, 32'h57e);
      wr(cix_pkg::OFS_ROM_DATA, 32'hbeef);
      setf(8'h7e);
      run(cix_pkg::OP_ROM_LO, 1'b0, 8'h20);
      chk(32'(polls), 32'h2);
      rchk(cix_pkg::OFS_WORK, 32'hef);
      run(cix_pkg::OP_ROM_HI, 1'b0, 8'h20);
      chk(32'(polls), 32'h2);
      rchk(cix_pkg::OFS_WORK, 32'hbe);
   endtask

   task automatic t_sleep;
      int n;
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      wr(cix_pkg::OFS_STATUS, 32'h0);
      wr(cix_pkg::OFS_INSTR, {16'h0, cix_pkg::OP_SLEEP, 9'h0});
      wr(cix_pkg::OFS_CTRL, 32'h1);
      n = 0;
      while (sleep_out !== 1'b1 && n < 10) begin
         @(negedge clk_in);
         n++;
      end
      chk({31'h0, sleep_out}, 32'h1);
      rchk(cix_pkg::OFS_STATUS, 32'h10);
      chk({31'h0, seen_clr}, 32'h1);
      wr(cix_pkg::OFS_CTRL, 32'h2);
      n = 0;
      while (sleep_out !== 1'b0 && n < 10) begin
         @(negedge clk_in);
         n++;
      end
      chk({31'h0, sleep_out}, 32'h0);
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rchk(cix_pkg::OFS_STATUS, 32'h18);
      t_shift();
      t_carry();
      t_sub();
      t_xor();
      t_skip();
      t_ret_rom();
      t_sleep();
      complete_run();
   end
endmodule
